// >>> verilog/cpa_pkg.sv
package cpa_pkg;

  // ------------------------------------------------------------------
  // register word indices (byte address = index * 4)
  // ------------------------------------------------------------------
  localparam logic [7:0] IDX_GATE      = 8'h04;
  localparam logic [7:0] IDX_DIRECT    = 8'h08;
  localparam logic [7:0] IDX_X_EXT     = 8'h09;
  localparam logic [7:0] IDX_Y_EXT     = 8'h0a;
  localparam logic [7:0] IDX_Z_EXT     = 8'h0b;
  localparam logic [7:0] IDX_JUMP      = 8'h0c;
  localparam logic [7:0] IDX_PTR_FIRST = 8'h1a;
  localparam logic [7:0] IDX_PTR_LAST  = 8'h1f;
  localparam logic [7:0] IDX_WIDE_BASE = 8'h20;

  // register-file addresses of the pointer bytes
  localparam logic [4:0] RF_PTR_FIRST  = 5'h1a;
  localparam logic [4:0] RF_PTR_LAST   = 5'h1f;

  // ------------------------------------------------------------------
  // protection gate
  // ------------------------------------------------------------------
  localparam logic [7:0] SIG_IO        = 8'hd8;
  localparam logic [7:0] SIG_INSN      = 8'h9d;
  localparam int         GATE_IO_BIT   = 0;
  localparam int         GATE_INSN_BIT = 1;
  localparam logic [2:0] WINDOW_STEPS  = 3'h4;

  // ------------------------------------------------------------------
  // reset values and sizes
  // ------------------------------------------------------------------
  localparam logic [7:0]  EXT_RESET    = 8'h00;
  localparam logic [15:0] PTR_RESET    = 16'h0000;
  localparam int          WIDE_BYTES   = 4;

  // extension slots
  localparam int EXT_X = 0;
  localparam int EXT_Y = 1;
  localparam int EXT_Z = 2;
  localparam int EXT_D = 3;
  localparam int EXT_J = 4;

  typedef enum logic [1:0] {
    PTR_NONE    = 2'b00,
    PTR_DISP    = 2'b01,
    PTR_POSTINC = 2'b10,
    PTR_PREDEC  = 2'b11
  } cpa_ptr_op_t;

  typedef enum logic [1:0] {
    PROG_NONE  = 2'b00,
    PROG_LOAD  = 2'b01,
    PROG_LOADX = 2'b10,
    PROG_STORE = 2'b11
  } cpa_prog_op_t;

  typedef struct packed {
    logic         rfWrEn;
    logic [4:0]   rfWrAddr;
    logic [7:0]   rfWrData;
    cpa_ptr_op_t  ptrOp;
    logic [1:0]   ptrSel;
    logic [5:0]   disp;
    logic [15:0]  directOperand;
    cpa_prog_op_t progOp;
    logic         progProtected;
    logic         instrStep;
    logic         ioWrite;
    logic         dataWrite;
    logic         sleepExec;
    logic         protRegWrite;
    logic         changeEnable;
  } cpa_cpu_req_t;

  typedef struct packed {
    logic [23:0] dataAddr;
    logic        dataAddrValid;
    logic [23:0] directAddr;
    logic [23:0] progAddr;
    logic        progGranted;
    logic [23:0] jumpAddr;
    logic        protWriteGranted;
    logic        irqHold;
    logic        ioWindowOpen;
    logic        insnWindowOpen;
  } cpa_cpu_rsp_t;

endpackage : cpa_pkg

// >>> verilog/cpa_window_cnt.sv
`timescale 1ns/1ns
module cpa_window_cnt #(
  parameter logic [2:0] LOAD = cpa_pkg::WINDOW_STEPS
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic load,
  input  wire logic step,
  input  wire logic cancel,
  output logic      open
);

  typedef struct packed {
    logic [2:0] count;
  } cpa_win_st_t;

  cpa_win_st_t st_ff;
  cpa_win_st_t nxt_st;

  // a signature write wins over a coincident cancel
  always_comb begin
    nxt_st = st_ff;
    if (load) begin
      nxt_st.count = LOAD;
    end else if (cancel) begin
      nxt_st.count = 3'h0;
    end else if (step && (st_ff.count != 3'h0)) begin
      nxt_st.count = st_ff.count - 3'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign open = (st_ff.count != 3'h0);

endmodule : cpa_window_cnt

// >>> verilog/cpa_atomic_reg.sv
`timescale 1ns/1ns
module cpa_atomic_reg #(
  parameter int NBYTES = cpa_pkg::WIDE_BYTES
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       wrEn,
  input  wire logic       rdEn,
  input  wire logic [2:0] idx,
  input  wire logic [7:0] wdata,
  output logic [7:0]      rdata
);

  // idx 0..NBYTES-1 are value bytes, NBYTES.. are the temporary latches
  typedef struct packed {
    logic [NBYTES-1:0][7:0] value;
    logic [NBYTES-2:0][7:0] temp;
  } cpa_wide_st_t;

  cpa_wide_st_t st_ff;
  cpa_wide_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // free-running count, so a torn read would be visible
    nxt_st.value = st_ff.value + 1'b1;
    if (rdEn && (idx == 3'h0)) begin
      for (int k = 0; k < NBYTES - 1; k++) begin
        nxt_st.temp[k] = st_ff.value[k+1];
      end
    end
    if (wrEn) begin
      if (int'(idx) == NBYTES - 1) begin
        nxt_st.value[NBYTES-1] = wdata;
        for (int k = 0; k < NBYTES - 1; k++) begin
          nxt_st.value[k] = st_ff.temp[k];
        end
      end else if (int'(idx) < NBYTES - 1) begin
        nxt_st.temp[idx] = wdata;
      end else begin
        nxt_st.temp[int'(idx) - NBYTES] = wdata;
      end
    end
  end

  always_comb begin
    if (idx == 3'h0) begin
      rdata = st_ff.value[0];
    end else if (int'(idx) < NBYTES) begin
      rdata = st_ff.temp[int'(idx) - 1];
    end else begin
      rdata = st_ff.temp[int'(idx) - NBYTES];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : cpa_atomic_reg

// >>> verilog/cpa_core.sv
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
// Notes on behaviour
// - top six register-file bytes pair into three 16-bit data pointers
// - lower register address is low byte, higher address is high byte
// - third pointer also addresses program flash, signature, fuses, locks
// - pointers support displacement, post-increment and pre-decrement
// - each pointer gets its own 8-bit extension as bits 23 to 16
// - extended loads and stores use third extension; plain load ignores it
// - direct extension sits above the 16-bit operand for direct addresses
// - jump extension sits above third pointer for far jumps and calls
// - low write goes to latch; high write commits latch same cycle
// - low read captures upper bytes into latch; high read returns latch
// - temporary latches are plain readable and writable locations
// - 24 and 32-bit registers use two and three latches, low first
// - protected writes and instructions need a prior gate signature
// - program store and fuse or signature loads are protected
// - io window closes on io or data write, store, load, sleep
// - instruction window lasts four steps, closes on data write or sleep
// - interrupts stay pending while any window is open
// - a programmed lock fuse blocks protected register changes
// - gate accepts d8 for io window and 9d for instruction window
// - gate reads bit 0 io window, bit 1 instruction window, rest zero
module cpa_core #(
  parameter int PADDR_W = 12
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [PADDR_W-1:0]    paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire cpa_pkg::cpa_cpu_req_t cpuReq,
  input  wire logic                  fuseLockPin,
  output cpa_pkg::cpa_cpu_rsp_t      cpuRsp
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [4:0][7:0]       ext;
    logic [2:0][15:0]      ptr;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  fuseSync1;
    logic                  fuseSync2;
    cpa_pkg::cpa_cpu_rsp_t rsp;
  } cpa_core_st_t;

  cpa_core_st_t st_ff;
  cpa_core_st_t nxt_st;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  logic [7:0] idx;
  logic       aligned;
  logic       setupPh;
  logic       accessPh;
  logic       wideHit;
  logic       ptrHit;
  logic       extHit;
  logic       gateHit;
  logic       hit;
  logic [7:0] wideRdata;
  logic [7:0] rdByte;
  logic       ioOpen;
  logic       insnOpen;
  logic       loadIo;
  logic       loadInsn;
  logic       cancelIo;
  logic       cancelInsn;

  assign idx      = paddr[9:2];
  assign aligned  = (paddr[1:0] == 2'b00) && (paddr[PADDR_W-1:10] == '0);
  assign setupPh  = psel && !penable;
  assign accessPh = psel && penable && st_ff.pready;

  assign wideHit  = aligned && (idx >= cpa_pkg::IDX_WIDE_BASE)
                 && (idx < cpa_pkg::IDX_WIDE_BASE
                           + 8'(2 * cpa_pkg::WIDE_BYTES - 1));
  assign ptrHit   = aligned && (idx >= cpa_pkg::IDX_PTR_FIRST)
                 && (idx <= cpa_pkg::IDX_PTR_LAST);
  assign extHit   = aligned && (idx >= cpa_pkg::IDX_DIRECT)
                 && (idx <= cpa_pkg::IDX_JUMP);
  assign gateHit  = aligned && (idx == cpa_pkg::IDX_GATE);
  assign hit      = wideHit || ptrHit || extHit || gateHit;

  // slot of an extension register from its bus index
  function automatic int ext_slot(input logic [7:0] i);
    int s;
    s = cpa_pkg::EXT_J;
    case (i)
      cpa_pkg::IDX_X_EXT:  s = cpa_pkg::EXT_X;
      cpa_pkg::IDX_Y_EXT:  s = cpa_pkg::EXT_Y;
      cpa_pkg::IDX_Z_EXT:  s = cpa_pkg::EXT_Z;
      cpa_pkg::IDX_DIRECT: s = cpa_pkg::EXT_D;
      default:             s = cpa_pkg::EXT_J;
    endcase
    return s;
  endfunction : ext_slot

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  logic [7:0] ptrOff;
  assign ptrOff = idx - cpa_pkg::IDX_PTR_FIRST;

  always_comb begin
    rdByte = 8'h00;
    if (gateHit) begin
      rdByte[cpa_pkg::GATE_IO_BIT]   = ioOpen;
      rdByte[cpa_pkg::GATE_INSN_BIT] = insnOpen;
    end else if (extHit) begin
      rdByte = st_ff.ext[ext_slot(idx)];
    end else if (ptrHit) begin
      rdByte = st_ff.ptr[ptrOff[2:1]][ptrOff[0]*8 +: 8];
    end else if (wideHit) begin
      rdByte = wideRdata;
    end
  end

  // ------------------------------------------------------------------
  // multi-byte atomic register
  // ------------------------------------------------------------------
  cpa_atomic_reg #(
    .NBYTES (cpa_pkg::WIDE_BYTES)
  ) u_wide (
    .clk     (clk),
    .reset_n (reset_n),
    .wrEn    (accessPh && pwrite && wideHit),
    .rdEn    (setupPh && !pwrite && wideHit),
    .idx     (3'(idx - cpa_pkg::IDX_WIDE_BASE)),
    .wdata   (pwdata[7:0]),
    .rdata   (wideRdata)
  );

  // ------------------------------------------------------------------
  // protection windows
  // ------------------------------------------------------------------
  // the protected write, the store and the load themselves cancel the io window only
  assign loadIo     = accessPh && pwrite && gateHit
                   && (pwdata[7:0] == cpa_pkg::SIG_IO);
  assign loadInsn   = accessPh && pwrite && gateHit
                   && (pwdata[7:0] == cpa_pkg::SIG_INSN);
  assign cancelIo   = cpuReq.ioWrite || cpuReq.dataWrite
                   || cpuReq.sleepExec || cpuReq.protRegWrite
                   || (cpuReq.progOp != cpa_pkg::PROG_NONE);
  assign cancelInsn = cpuReq.dataWrite || cpuReq.sleepExec;

  cpa_window_cnt #(
    .LOAD (cpa_pkg::WINDOW_STEPS)
  ) u_io_win (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (loadIo),
    .step    (cpuReq.instrStep),
    .cancel  (cancelIo),
    .open    (ioOpen)
  );

  cpa_window_cnt #(
    .LOAD (cpa_pkg::WINDOW_STEPS)
  ) u_insn_win (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (loadInsn),
    .step    (cpuReq.instrStep),
    .cancel  (cancelInsn),
    .open    (insnOpen)
  );

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  logic [23:0] base;
  logic [23:0] moved;
  logic [4:0]  rfOff;
  int          sel;

  always_comb begin
    nxt_st = st_ff;
    base   = 24'h000000;
    moved  = 24'h000000;
    rfOff  = 5'h00;
    sel    = 0;

    // fuse pin comes from outside the clock domain
    nxt_st.fuseSync1 = fuseLockPin;
    nxt_st.fuseSync2 = st_ff.fuseSync1;

    // apb: one access cycle, read side effects taken at setup
    nxt_st.pready  = 1'b0;
    nxt_st.pslverr = 1'b0;
    if (setupPh) begin
      nxt_st.pready  = 1'b1;
      nxt_st.pslverr = !hit;
      nxt_st.prdata  = {24'h000000, rdByte};
      if (pwrite || !hit) begin
        nxt_st.prdata = 32'h00000000;
      end
    end

    if (accessPh && pwrite && extHit) begin
      nxt_st.ext[ext_slot(idx)] = pwdata[7:0];
    end
    if (accessPh && pwrite && ptrHit) begin
      nxt_st.ptr[ptrOff[2:1]][ptrOff[0]*8 +: 8] = pwdata[7:0];
    end

    // register-file writes from the core take priority over the bus
    if (cpuReq.rfWrEn && (cpuReq.rfWrAddr >= cpa_pkg::RF_PTR_FIRST)
        && (cpuReq.rfWrAddr <= cpa_pkg::RF_PTR_LAST)) begin
      rfOff = cpuReq.rfWrAddr - cpa_pkg::RF_PTR_FIRST;
      nxt_st.ptr[rfOff[2:1]][rfOff[0]*8 +: 8] = cpuReq.rfWrData;
    end

    // pointer addressing modes carry into the extension byte
    sel  = (cpuReq.ptrSel > 2'd2) ? 2 : int'(cpuReq.ptrSel);
    base = {st_ff.ext[sel], st_ff.ptr[sel]};
    nxt_st.rsp.dataAddrValid = (cpuReq.ptrOp != cpa_pkg::PTR_NONE);
    nxt_st.rsp.dataAddr      = base;
    case (cpuReq.ptrOp)
      cpa_pkg::PTR_DISP: begin
        nxt_st.rsp.dataAddr = base + {18'h00000, cpuReq.disp};
      end
      cpa_pkg::PTR_POSTINC: begin
        moved           = base + 24'h000001;
        nxt_st.ext[sel] = moved[23:16];
        nxt_st.ptr[sel] = moved[15:0];
      end
      cpa_pkg::PTR_PREDEC: begin
        moved               = base - 24'h000001;
        nxt_st.rsp.dataAddr = moved;
        nxt_st.ext[sel]     = moved[23:16];
        nxt_st.ptr[sel]     = moved[15:0];
      end
      default: begin
        nxt_st.rsp.dataAddr = base;
      end
    endcase

    nxt_st.rsp.directAddr = {st_ff.ext[cpa_pkg::EXT_D],
                             cpuReq.directOperand};
    nxt_st.rsp.jumpAddr   = {st_ff.ext[cpa_pkg::EXT_J],
                             st_ff.ptr[2]};

    // program memory through the third pointer
    case (cpuReq.progOp)
      cpa_pkg::PROG_LOAD: begin
        nxt_st.rsp.progAddr    = {8'h00, st_ff.ptr[2]};
        nxt_st.rsp.progGranted = !cpuReq.progProtected
                              || insnOpen;
      end
      cpa_pkg::PROG_LOADX: begin
        nxt_st.rsp.progAddr    = {st_ff.ext[cpa_pkg::EXT_Z],
                                  st_ff.ptr[2]};
        nxt_st.rsp.progGranted = !cpuReq.progProtected
                              || insnOpen;
      end
      cpa_pkg::PROG_STORE: begin
        nxt_st.rsp.progAddr    = {st_ff.ext[cpa_pkg::EXT_Z],
                                  st_ff.ptr[2]};
        nxt_st.rsp.progGranted = insnOpen;
      end
      default: begin
        nxt_st.rsp.progAddr    = {8'h00, st_ff.ptr[2]};
        nxt_st.rsp.progGranted = 1'b0;
      end
    endcase

    // a protected write needs the window, its enable bit and no lock
    nxt_st.rsp.protWriteGranted = cpuReq.protRegWrite && ioOpen
                               && cpuReq.changeEnable
                               && !st_ff.fuseSync2;

    // hold interrupts from the signature write itself onward
    nxt_st.rsp.irqHold        = ioOpen || insnOpen
                             || loadIo || loadInsn;
    nxt_st.rsp.ioWindowOpen   = ioOpen;
    nxt_st.rsp.insnWindowOpen = insnOpen;
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff     <= '0;
      st_ff.ext <= {5{cpa_pkg::EXT_RESET}};
      st_ff.ptr <= {3{cpa_pkg::PTR_RESET}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata  = st_ff.prdata;
  assign pready  = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign cpuRsp  = st_ff.rsp;

endmodule : cpa_core

// >>> bench/cpa_checker.sv
`timescale 1ns/1ns
module cpa_checker #(
  parameter int PADDR_W = 12
) (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [PADDR_W-1:0]    paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire cpa_pkg::cpa_cpu_req_t cpuReq,
  input wire logic                  fuseLockPin,
  input wire cpa_pkg::cpa_cpu_rsp_t cpuRsp
);
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  localparam logic [PADDR_W-1:0] GATE_ADDR =
    PADDR_W'({cpa_pkg::IDX_GATE, 2'b00});
  logic gateHit;
  logic gateWr;
  logic ioKill;
  assign gateHit = psel && penable && paddr == GATE_ADDR;
  assign gateWr  = gateHit && pready && pwrite;
  assign ioKill  = cpuReq.ioWrite || cpuReq.dataWrite || cpuReq.sleepExec
                   || cpuReq.progOp != cpa_pkg::PROG_NONE
                   || cpuReq.protRegWrite;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence setupS;
    psel && !penable;
  endsequence
  sequence accessS;
    psel && penable;
  endsequence
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  ready_in_access_a: assert property (setupS ##1 accessS |-> pready)
    else $error("pready missing in first access cycle");
  ready_only_a: assert property (pready |-> psel && penable
    && $past(psel && !penable)) else $error("pready outside access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("prdata upper bits not zero");
  gate_read_a: assert property (gateHit && pready && !pwrite
    |-> prdata[7:2] == 6'h00) else $error("gate high bits not zero");
  io_open_a: assert property (gateWr
    && pwdata[7:0] == cpa_pkg::SIG_IO |-> ##[1:2] cpuRsp.ioWindowOpen)
    else $error("io window did not open");
  irq_hold_a: assert property (gateWr
    && pwdata[7:0] == cpa_pkg::SIG_INSN |-> ##[1:2] cpuRsp.irqHold)
    else $error("interrupts not held");
  io_cancel_a: assert property (ioKill && !gateWr
    |-> ##2 !cpuRsp.ioWindowOpen) else $error("io window not closed");
  insn_cancel_a: assert property ((cpuReq.dataWrite
    || cpuReq.sleepExec) && !gateWr |-> ##2 !cpuRsp.insnWindowOpen)
    else $error("instruction window not closed");
  grant_cause_a: assert property (cpuRsp.protWriteGranted
    |-> $past(cpuReq.protRegWrite && cpuReq.changeEnable))
    else $error("protected write granted without request");
  plain_load_a: assert property (cpuReq.progOp == cpa_pkg::PROG_LOAD
    |=> cpuRsp.progAddr[23:16] == 8'h00) else $error("load used ext");
  direct_low_a: assert property (1'b1
    |=> cpuRsp.directAddr[15:0] == $past(cpuReq.directOperand))
    else $error("direct address low part wrong");
  fuse_block_a: assert property (fuseLockPin[*4]
    |=> !cpuRsp.protWriteGranted) else $error("locked write granted");
endmodule : cpa_checker

bind cpa_core cpa_checker #(.PADDR_W(PADDR_W)) u_cpa_checker (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cpuReq(cpuReq),
  .fuseLockPin(fuseLockPin), .cpuRsp(cpuRsp)
);

// >>> bench/cpa_cpu_model.sv
`timescale 1ns/1ns
module cpa_cpu_model (
  input  wire logic             clk,
  output cpa_pkg::cpa_cpu_req_t cpuReq,
  output logic                  fuseLockPin
);
  // ------------------------------------------------------------------
  // instruction issue
  // ------------------------------------------------------------------
  initial begin
    cpuReq = '0;
    fuseLockPin = 1'b0;
  end
  // each issued instruction is one instruction cycle; an idle core does
  // not age the windows, so a caller controls the step count exactly
  task automatic issue(input cpa_pkg::cpa_cpu_req_t r);
    r.instrStep = 1'b1;
    @(posedge clk);
    cpuReq <= r;
    @(posedge clk);
    cpuReq <= '0;
  endtask : issue
  task automatic setLock(input logic v);
    @(posedge clk);
    fuseLockPin <= v;
  endtask : setLock
endmodule : cpa_cpu_model

// >>> bench/tb.sv
`timescale 1ns/1ns
module tb;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, fuse, errv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, wide;
  logic [7:0]  rdv;
  cpa_pkg::cpa_cpu_req_t cpuReq, q;
  cpa_pkg::cpa_cpu_rsp_t cpuRsp;
  int error_cnt, num_checks, i;
  localparam logic [7:0] G = cpa_pkg::IDX_GATE;
  localparam logic [7:0] W = cpa_pkg::IDX_WIDE_BASE;

  cpa_core u_cpa_core (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpuReq(cpuReq),
    .fuseLockPin(fuse), .cpuRsp(cpuRsp)
  );
  cpa_cpu_model u_cpa_cpu_model (
    .clk(clk), .cpuReq(cpuReq), .fuseLockPin(fuse)
  );
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (n = 0; pready !== 1'b1 && n < 16; n++)
      @(posedge clk);
    if (n == 16) begin
      error_cnt++;
      final_report();
    end
    rdv = prdata[7:0];
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check({16'h0000, rdv}, {16'h0000, exp});
  endtask : rdc
  task automatic op(input cpa_pkg::cpa_cpu_req_t r);
    u_cpa_cpu_model.issue(r);
    @(negedge clk);
  endtask : op
  task automatic act(input int k);
    q = '0;
    case (k)
      1: q.ioWrite = 1'b1;
      2: q.dataWrite = 1'b1;
      3: q.sleepExec = 1'b1;
      4: q.progOp = cpa_pkg::PROG_LOAD;
      5: q.progOp = cpa_pkg::PROG_STORE;
      6: {q.protRegWrite, q.changeEnable} = 2'b11;
      7: q.protRegWrite = 1'b1;
      8: {q.progOp, q.progProtected} = {cpa_pkg::PROG_LOAD, 1'b1};
      default: q.ptrOp = cpa_pkg::PTR_NONE;
    endcase
    op(q);
  endtask : act
  task automatic rf(input logic [4:0] a, input logic [7:0] d);
    q = '0;
    {q.rfWrEn, q.rfWrAddr, q.rfWrData} = {1'b1, a, d};
    op(q);
  endtask : rf
  task automatic ptr(input cpa_pkg::cpa_ptr_op_t o, input logic [1:0] s);
    q = '0;
    {q.ptrOp, q.ptrSel, q.disp} = {o, s, 6'h05};
    op(q);
  endtask : ptr
  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
    error_cnt = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    for (i = 0; i < 5; i++)
      rdc(cpa_pkg::IDX_DIRECT + 8'(i), cpa_pkg::EXT_RESET);
    for (i = 0; i < 5; i++)
      apb(1'b1, cpa_pkg::IDX_DIRECT + 8'(i), 8'ha0 + 8'(i));
    for (i = 0; i < 5; i++)
      rdc(cpa_pkg::IDX_DIRECT + 8'(i), 8'ha0 + 8'(i));
    apb(1'b0, 8'h10, 8'h00);
    check({15'h0000, errv, rdv}, 24'h000100);
    for (i = 0; i < 6; i++) begin
      rf(cpa_pkg::RF_PTR_FIRST + 5'(i), 8'h10 + 8'(i));
      rdc(cpa_pkg::IDX_PTR_FIRST + 8'(i), 8'h10 + 8'(i));
    end
    for (i = 0; i < 3; i++) begin
      ptr(cpa_pkg::PTR_DISP, 2'(i));
      check(cpuRsp.dataAddr, {8'ha1 + 8'(i), 8'h11 + 8'(2 * i),
            8'h10 + 8'(2 * i)} + 24'h000005);
      check({23'h000000, cpuRsp.dataAddrValid}, 24'h000001);
    end
    q = '0;
    {q.directOperand, q.progOp} = {16'hbeef, cpa_pkg::PROG_LOADX};
    op(q);
    check(cpuRsp.directAddr, 24'ha0beef);
    check(cpuRsp.progAddr, 24'ha31514);
    check(cpuRsp.jumpAddr, 24'ha41514);
    act(4);
    check(cpuRsp.progAddr, 24'h001514);
    check({23'h000000, cpuRsp.progGranted}, 24'h000001);
    rf(5'h1e, 8'hff);
    rf(5'h1f, 8'hff);
    ptr(cpa_pkg::PTR_POSTINC, 2'h2);
    check(cpuRsp.dataAddr, 24'ha3ffff);
    rdc(cpa_pkg::IDX_Z_EXT, 8'ha4);
    ptr(cpa_pkg::PTR_PREDEC, 2'h2);
    check(cpuRsp.dataAddr, 24'ha3ffff);
    act(5);
    check({23'h000000, cpuRsp.progGranted}, 24'h000000);
    act(8);
    check({23'h000000, cpuRsp.progGranted}, 24'h000000);
    apb(1'b1, G, cpa_pkg::SIG_INSN);
    rdc(G, 8'h02);
    act(5);
    check({23'h000000, cpuRsp.progGranted}, 24'h000001);
    check({23'h000000, cpuRsp.insnWindowOpen}, 24'h000001);
    apb(1'b1, G, cpa_pkg::SIG_INSN);
    for (i = 0; i < 4; i++)
      act(0);
    act(5);
    check({23'h000000, cpuRsp.progGranted}, 24'h000000);
    apb(1'b1, G, cpa_pkg::SIG_INSN);
    act(2);
    act(8);
    check({23'h000000, cpuRsp.progGranted}, 24'h000000);
    apb(1'b1, G, 8'h55);
    rdc(G, 8'h00);
    apb(1'b1, G, cpa_pkg::SIG_IO);
    rdc(G, 8'h01);
    act(0);
    check({23'h000000, cpuRsp.irqHold}, 24'h000001);
    act(6);
    check({23'h000000, cpuRsp.protWriteGranted}, 24'h000001);
    apb(1'b1, G, cpa_pkg::SIG_IO);
    act(7);
    check({23'h000000, cpuRsp.protWriteGranted}, 24'h000000);
    for (i = 1; i < 5; i++) begin
      apb(1'b1, G, cpa_pkg::SIG_IO);
      act(i);
      act(6);
      check({23'h000000, cpuRsp.protWriteGranted}, 24'h000000);
    end
    u_cpa_cpu_model.setLock(1'b1);
    apb(1'b1, G, cpa_pkg::SIG_IO);
    act(6);
    check({23'h000000, cpuRsp.protWriteGranted}, 24'h000000);
    u_cpa_cpu_model.setLock(1'b0);
    apb(1'b1, W, 8'hfe);
    apb(1'b1, W + 8'h01, 8'h22);
    apb(1'b1, W + 8'h02, 8'h33);
    rdc(W + 8'h04, 8'hfe);
    rdc(W + 8'h05, 8'h22);
    rdc(W + 8'h06, 8'h33);
    apb(1'b1, W + 8'h03, 8'h44);
    for (i = 0; i < 4; i++) begin
      apb(1'b0, W + 8'(i), 8'h00);
      wide[8 * i +: 8] = rdv;
    end
    // a torn read shows the carry out of the low byte as a jump of 0x100
    check({23'h000000, (wide - 32'h443322fe) inside {[1:40]}},
          24'h000001);
    final_report();
  end
endmodule : tb
